// ==== shared/synth_pkg.sv ====
package synth_pkg;

    // serial word and latch selection
    localparam int         WORD_W     = 24;
    localparam logic [1:0] SEL_MAIN   = 2'h0;
    localparam logic [1:0] SEL_REF    = 2'h1;
    localparam logic [1:0] SEL_FB     = 2'h2;
    localparam logic [1:0] SEL_TEST   = 2'h3;
    localparam logic [23:0] WORD_RST  = 24'h000000;

    // main configuration word fields
    localparam int CORE_BIAS_LSB = 2;
    localparam int CLR_BIT       = 4;
    localparam int MON_LSB       = 5;
    localparam int POL_BIT       = 8;
    localparam int PUMP_TRI_BIT  = 9;
    localparam int GAIN_MAIN_BIT = 10;
    localparam int MUTE_BIT      = 11;
    localparam int OUT_PWR_LSB   = 12;
    localparam int CUR1_LSB      = 14;
    localparam int CUR2_LSB      = 17;
    localparam int PD_REQ_BIT    = 20;
    localparam int PD_SYNC_BIT   = 21;
    localparam int MOD_LSB       = 22;

    // reference divider word fields
    localparam int R_LSB         = 2;
    localparam int R_W           = 14;
    localparam int ABP_LSB       = 16;
    localparam int LDP_BIT       = 18;
    localparam int TEST_BIT      = 19;
    localparam int BSC_LSB       = 20;

    // feedback divider word fields
    localparam int A_LSB         = 2;
    localparam int A_W           = 5;
    localparam int B_LSB         = 8;
    localparam int B_W           = 13;
    localparam int GAIN_FB_BIT   = 21;
    localparam int HALF_BIT      = 22;
    localparam int PSRC_BIT      = 23;

    // test latch bits steering band and current control
    localparam int TL_EXT_BAND_BIT = 2;
    localparam int TL_BAND_ICP_BIT = 3;
    localparam int TL_SAR_ICP_BIT  = 4;

    // counts and decoded values
    localparam logic [2:0] LOCK_CNT_FINE   = 3'h5;
    localparam logic [2:0] LOCK_CNT_COARSE = 3'h3;
    localparam logic [1:0] PD_SYNC_LAST    = 2'h1;  // second edge after strobe
    localparam logic [5:0] MOD_8           = 6'h08;
    localparam logic [5:0] MOD_16          = 6'h10;
    localparam logic [5:0] MOD_32          = 6'h20;
    // anti-backlash widths in tenths of a nanosecond
    localparam logic [5:0] ABP_W_NORM      = 6'h1e;
    localparam logic [5:0] ABP_W_SHORT     = 6'h0f;
    localparam logic [5:0] ABP_W_LONG      = 6'h3c;

    typedef enum logic [2:0] {
        MON_TRI    = 3'b000,
        MON_LOCK   = 3'b001,
        MON_FB     = 3'b010,
        MON_HIGH   = 3'b011,
        MON_REF    = 3'b100,
        MON_OD     = 3'b101,
        MON_SDO    = 3'b110,
        MON_LOW    = 3'b111
    } mon_sel_t;

    typedef enum logic [1:0] {
        PWR_INIT   = 2'b00,
        PWR_RUN    = 2'b01,
        PWR_SYNC   = 2'b10,
        PWR_DOWN   = 2'b11
    } pwr_state_t;

endpackage

// ==== shared/rdiv_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface rdiv_if;
    logic [13:0] ratio;
    logic        clear;
    logic        tick;
    logic        pulse;
    modport owner   (output ratio, output clear, output tick, input pulse);
    modport divider (input ratio, input clear, input tick, output pulse);
endinterface
`default_nettype wire

// ==== core/ref_divider.sv ====
`timescale 1ns/100ps
`default_nettype none
module ref_divider (
    input  wire logic   clk,
    input  wire logic   rst,
    input  wire logic   ce,
    rdiv_if.divider     d
);
    logic [13:0] count_reg;
    logic        pulse_reg;
    logic [13:0] count_inc;
    logic        wrap;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // a ratio of zero behaves as one, so the divider never stalls
    assign count_inc = count_reg + 14'h0001;
    assign wrap      = (count_inc >= d.ratio);
    assign d.pulse   = pulse_reg;

    // counts reference ticks and pulses once per ratio
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_reg <= 14'h0000;
            pulse_reg <= 1'b0;
        end else if (ce) begin
            if (d.clear) begin
                count_reg <= 14'h0000;
                pulse_reg <= 1'b0;
            end else begin
                pulse_reg <= d.tick && wrap;
                if (d.tick) begin
                    count_reg <= wrap ? 14'h0000 : count_inc;
                end
            end
        end
    end

    AST_RDIV_CLEAR: assert property (ce && d.clear |=> count_reg == 14'h0000 && !pulse_reg)
        else $error("reference counter not held by clear");
    AST_RDIV_WRAP: assert property (ce && !d.clear && d.tick && wrap |=> pulse_reg && count_reg == 14'h0000)
        else $error("reference divider missed its terminal count");
endmodule
`default_nettype wire

// ==== core/synth_latch_programming.sv ====
`timescale 1ns/100ps
`default_nettype none
module synth_latch_programming (
    input  wire logic   clk,
    input  wire logic   rst,
    input  wire logic   ce,
    input  wire logic   ser_clk,
    input  wire logic   ser_data,
    input  wire logic   load_strobe,
    input  wire logic   ref_tick,
    input  wire logic   fb_tick,
    input  wire logic   phase_in_window,
    output logic        monitor_pin_out,
    output logic        monitor_pin_oe_n,
    output logic        digital_lock,
    output logic        rf_out_en,
    output logic        pump_tristate,
    output logic        pump_gain_select,
    output logic [2:0]  pump_current,
    output logic [1:0]  core_bias,
    output logic [1:0]  output_power,
    output logic [5:0]  backlash_width,
    output logic [5:0]  prescaler_modulus,
    output logic        output_halving,
    output logic        prescaler_source,
    output logic        detector_polarity,
    output logic        powered_down,
    output logic        counters_held,
    output logic        band_clk_tick,
    output logic        fb_pulse,
    output logic        test_mode_active,
    output logic        ext_band_sel,
    output logic        band_icp_ctrl,
    output logic        sar_icp_ctrl
);
    logic [23:0] shift_reg, main_reg, refw_reg, fb_reg, test_reg;
    logic [23:0] shift_next;
    logic        sclk_prev_reg, le_prev_reg;
    logic [2:0]  seen_reg;
    synth_pkg::pwr_state_t pwr_reg, pwr_next;
    logic [1:0]  sync_cnt_reg;
    logic [2:0]  lock_cnt_reg, lock_need, lock_cnt_inc;
    logic        lock_reg;
    logic [2:0]  bsc_cnt_reg, bsc_top;
    logic [18:0] fb_cnt_reg, fb_cnt_inc, n_total;
    logic        fb_pulse_reg, band_tick_reg, hold_reg, gain_reg;
    logic        mon_out_reg, mon_oe_n_reg, rf_en_reg, pump_tri_reg, down_reg;
    logic        test_reg_q, ext_band_reg, band_icp_reg, sar_icp_reg;
    logic [2:0]  pump_cur_reg;
    logic [5:0]  backlash_reg, modulus_reg;
    logic        sclk_rise, le_rise, load_main, load_ref, load_fb, load_test;
    logic [1:0]  word_sel, mod_code, abp_code, bsc_code;
    logic [2:0]  mon_sel;
    logic        pd_req, pd_sync, pd_async, mute, test_en, r_pulse, lock_next, fb_wrap;
    logic        hold_next, mon_out_next, mon_oe_n_next, rf_en_next, pump_tri_next;
    logic [5:0]  modulus_val, backlash_next;
    localparam int A_W_C = synth_pkg::A_W;
    localparam int B_W_C = synth_pkg::B_W;
    logic [A_W_C-1:0] a_val;
    logic [B_W_C-1:0] b_val;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    rdiv_if rdiv ();

    // serial port edges; pins are taken as already synchronous
    assign sclk_rise  = ser_clk & ~sclk_prev_reg;
    assign le_rise    = load_strobe & ~le_prev_reg;
    assign shift_next = {shift_reg[22:0], ser_data};
    assign word_sel   = shift_reg[1:0];
    assign load_main  = le_rise && (word_sel == synth_pkg::SEL_MAIN);
    assign load_ref   = le_rise && (word_sel == synth_pkg::SEL_REF);
    assign load_fb    = le_rise && (word_sel == synth_pkg::SEL_FB);
    assign load_test  = le_rise && (word_sel == synth_pkg::SEL_TEST);

    // field decode from the held words
    assign mon_sel   = main_reg[synth_pkg::MON_LSB +: 3];
    assign pd_req    = main_reg[synth_pkg::PD_REQ_BIT];
    assign pd_sync   = main_reg[synth_pkg::PD_SYNC_BIT];
    assign pd_async  = pd_req & ~pd_sync;
    assign mute      = main_reg[synth_pkg::MUTE_BIT];
    assign mod_code  = main_reg[synth_pkg::MOD_LSB +: 2];
    assign abp_code  = refw_reg[synth_pkg::ABP_LSB +: 2];
    assign bsc_code  = refw_reg[synth_pkg::BSC_LSB +: 2];
    assign test_en   = refw_reg[synth_pkg::TEST_BIT];
    assign a_val     = fb_reg[synth_pkg::A_LSB +: A_W_C];
    assign b_val     = fb_reg[synth_pkg::B_LSB +: B_W_C];

    // the reference divider sits in its own module, fed from the ratio field
    assign rdiv.ratio = refw_reg[synth_pkg::R_LSB +: synth_pkg::R_W];
    assign rdiv.clear = hold_reg;
    assign rdiv.tick  = ref_tick;
    assign r_pulse    = rdiv.pulse;

    ref_divider u_rdiv (
        .clk (clk),
        .rst (rst),
        .ce  (ce),
        .d   (rdiv)
    );

    // shift register and strobe edge detectors
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_reg     <= synth_pkg::WORD_RST;
            sclk_prev_reg <= 1'b0;
            le_prev_reg   <= 1'b0;
        end else if (ce) begin
            sclk_prev_reg <= ser_clk;
            le_prev_reg   <= load_strobe;
            if (sclk_rise) begin
                shift_reg <= shift_next;
            end
        end
    end

    // latch transfer; a strobe in the same cycle as a clock edge takes the old word
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            main_reg <= synth_pkg::WORD_RST;
            refw_reg <= synth_pkg::WORD_RST;
            fb_reg   <= synth_pkg::WORD_RST;
            test_reg <= synth_pkg::WORD_RST;
            seen_reg <= 3'h0;
            gain_reg <= 1'b0;
        end else if (ce) begin
            if (load_main) main_reg <= shift_reg;
            if (load_ref)  refw_reg <= shift_reg;
            if (load_fb)   fb_reg   <= shift_reg;
            if (load_test) test_reg <= shift_reg;
            seen_reg <= seen_reg | {load_fb, load_ref, load_main};
            if (load_main) begin
                gain_reg <= shift_reg[synth_pkg::GAIN_MAIN_BIT];
            end else if (load_fb) begin
                gain_reg <= shift_reg[synth_pkg::GAIN_FB_BIT];
            end
        end
    end

    // power sequencing: stays down until all three words have arrived
    always_comb begin
        pwr_next = pwr_reg;
        case (pwr_reg)
            synth_pkg::PWR_INIT: begin
                if (&seen_reg) pwr_next = synth_pkg::PWR_RUN;
            end
            synth_pkg::PWR_RUN: begin
                if (pd_req) pwr_next = pd_sync ? synth_pkg::PWR_SYNC : synth_pkg::PWR_DOWN;
            end
            synth_pkg::PWR_SYNC: begin
                if (!pd_req) pwr_next = synth_pkg::PWR_RUN;
                else if (!pd_sync) pwr_next = synth_pkg::PWR_DOWN;
                else if (r_pulse && sync_cnt_reg == synth_pkg::PD_SYNC_LAST) pwr_next = synth_pkg::PWR_DOWN;
            end
            synth_pkg::PWR_DOWN: begin
                if (!pd_req) pwr_next = synth_pkg::PWR_RUN;
            end
            default: pwr_next = synth_pkg::PWR_INIT;
        endcase
    end

    // sync power-down counts reference pulses from entry to the sync state, one cycle after the word landed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwr_reg      <= synth_pkg::PWR_INIT;
            sync_cnt_reg <= 2'h0;
        end else if (ce) begin
            pwr_reg      <= pwr_next;
            sync_cnt_reg <= (pwr_reg != synth_pkg::PWR_SYNC) ? 2'h0 : sync_cnt_reg + {1'b0, r_pulse};
        end
    end

    // counters held by the clear bit, by initialisation and by power-down
    assign hold_next = main_reg[synth_pkg::CLR_BIT] | (pwr_reg == synth_pkg::PWR_INIT)
                     | (pwr_reg == synth_pkg::PWR_DOWN);

    // lock detect: consecutive in-window reference cycles
    assign lock_need    = refw_reg[synth_pkg::LDP_BIT] ? synth_pkg::LOCK_CNT_FINE : synth_pkg::LOCK_CNT_COARSE;
    // saturate at the target so a precision change never leaves the count above it
    assign lock_cnt_inc = (lock_cnt_reg >= lock_need) ? lock_need : lock_cnt_reg + 3'h1;
    assign lock_next    = (lock_cnt_inc >= lock_need);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_cnt_reg <= 3'h0;
            lock_reg     <= 1'b0;
        end else if (ce) begin
            if (hold_reg) begin
                lock_cnt_reg <= 3'h0;
                lock_reg     <= 1'b0;
            end else if (r_pulse) begin
                lock_cnt_reg <= phase_in_window ? lock_cnt_inc : 3'h0;
                lock_reg     <= phase_in_window & lock_next;
            end
        end
    end

    // band clock divider: terminal counts 0, 1, 3, 7 give 1, 2, 4, 8
    assign bsc_top = {bsc_code == 2'h3, bsc_code[1], bsc_code != 2'h0};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bsc_cnt_reg   <= 3'h0;
            band_tick_reg <= 1'b0;
        end else if (ce) begin
            if (hold_reg) begin
                bsc_cnt_reg   <= 3'h0;
                band_tick_reg <= 1'b0;
            end else begin
                band_tick_reg <= r_pulse && (bsc_cnt_reg == bsc_top);
                if (r_pulse) bsc_cnt_reg <= (bsc_cnt_reg == bsc_top) ? 3'h0 : bsc_cnt_reg + 3'h1;
            end
        end
    end

    // feedback division: 19 bits cover 32 times 8191 plus 31
    assign modulus_val = (mod_code == 2'h0) ? synth_pkg::MOD_8 :
                         (mod_code == 2'h1) ? synth_pkg::MOD_16 : synth_pkg::MOD_32;
    assign n_total     = 19'(modulus_val) * 19'(b_val) + 19'(a_val);
    assign fb_cnt_inc  = fb_cnt_reg + 19'h00001;
    assign fb_wrap     = (fb_cnt_inc >= n_total);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fb_cnt_reg   <= 19'h00000;
            fb_pulse_reg <= 1'b0;
        end else if (ce) begin
            if (hold_reg) begin
                fb_cnt_reg   <= 19'h00000;
                fb_pulse_reg <= 1'b0;
            end else begin
                fb_pulse_reg <= fb_tick && fb_wrap;
                if (fb_tick) fb_cnt_reg <= fb_wrap ? 19'h00000 : fb_cnt_inc;
            end
        end
    end

    // monitor pin selection; open-drain lock only pulls low while unlocked
    assign mon_out_next  = (mon_sel == synth_pkg::MON_LOCK) ? lock_reg :
                           (mon_sel == synth_pkg::MON_FB)   ? fb_pulse_reg :
                           (mon_sel == synth_pkg::MON_HIGH) ? 1'b1 :
                           (mon_sel == synth_pkg::MON_REF)  ? r_pulse :
                           (mon_sel == synth_pkg::MON_SDO)  ? shift_reg[23] : 1'b0;
    assign mon_oe_n_next = (mon_sel == synth_pkg::MON_TRI)
                         | ((mon_sel == synth_pkg::MON_OD) & lock_reg);

    // pump off during init or power-down regardless of the programmed bit
    assign pump_tri_next = (pwr_reg == synth_pkg::PWR_INIT) | (pwr_reg == synth_pkg::PWR_DOWN)
                         | main_reg[synth_pkg::PUMP_TRI_BIT];
    assign rf_en_next    = ((pwr_reg == synth_pkg::PWR_RUN) | (pwr_reg == synth_pkg::PWR_SYNC))
                         & (~mute | lock_reg);
    assign backlash_next = (abp_code == 2'h1) ? synth_pkg::ABP_W_SHORT :
                           (abp_code == 2'h2) ? synth_pkg::ABP_W_LONG : synth_pkg::ABP_W_NORM;

    // output registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_reg     <= 1'b1;
            mon_out_reg  <= 1'b0;
            mon_oe_n_reg <= 1'b1;
            rf_en_reg    <= 1'b0;
            pump_tri_reg <= 1'b1;
            down_reg     <= 1'b1;
            pump_cur_reg <= 3'h0;
            backlash_reg <= synth_pkg::ABP_W_NORM;
            modulus_reg  <= synth_pkg::MOD_8;
            test_reg_q   <= 1'b0;
            ext_band_reg <= 1'b0;
            band_icp_reg <= 1'b1;
            sar_icp_reg  <= 1'b1;
        end else if (ce) begin
            hold_reg     <= hold_next;
            mon_out_reg  <= mon_out_next;
            mon_oe_n_reg <= mon_oe_n_next;
            rf_en_reg    <= rf_en_next;
            pump_tri_reg <= pump_tri_next;
            down_reg     <= (pwr_next == synth_pkg::PWR_INIT) | (pwr_next == synth_pkg::PWR_DOWN);
            pump_cur_reg <= gain_reg ? main_reg[synth_pkg::CUR2_LSB +: 3] : main_reg[synth_pkg::CUR1_LSB +: 3];
            backlash_reg <= backlash_next;
            modulus_reg  <= modulus_val;
            test_reg_q   <= test_en;
            ext_band_reg <= test_en & test_reg[synth_pkg::TL_EXT_BAND_BIT];
            band_icp_reg <= ~test_en | test_reg[synth_pkg::TL_BAND_ICP_BIT];
            sar_icp_reg  <= ~test_en | test_reg[synth_pkg::TL_SAR_ICP_BIT];
        end
    end

    // plain field outputs come straight from the latch flops; the monitor, lock, RF, pump and divider outputs come from the output registers
    assign core_bias         = main_reg[synth_pkg::CORE_BIAS_LSB +: 2];
    assign output_power      = main_reg[synth_pkg::OUT_PWR_LSB +: 2];
    assign detector_polarity = main_reg[synth_pkg::POL_BIT];
    assign output_halving    = fb_reg[synth_pkg::HALF_BIT];
    assign prescaler_source  = fb_reg[synth_pkg::PSRC_BIT];
    assign pump_gain_select  = gain_reg;
    assign monitor_pin_out   = mon_out_reg;
    assign monitor_pin_oe_n  = mon_oe_n_reg;
    assign digital_lock      = lock_reg;
    assign rf_out_en         = rf_en_reg;
    assign pump_tristate     = pump_tri_reg;
    assign pump_current      = pump_cur_reg;
    assign backlash_width    = backlash_reg;
    assign prescaler_modulus = modulus_reg;
    assign powered_down      = down_reg;
    assign counters_held     = hold_reg;
    assign band_clk_tick     = band_tick_reg;
    assign fb_pulse          = fb_pulse_reg;
    assign test_mode_active  = test_reg_q;
    assign ext_band_sel      = ext_band_reg;
    assign band_icp_ctrl     = band_icp_reg;
    assign sar_icp_ctrl      = sar_icp_reg;

    AST_LOAD_MAIN: assert property (ce && load_main |=> main_reg == $past(shift_reg))
        else $error("main word not transferred on strobe");
    AST_MON_HIGH: assert property (ce && mon_sel == synth_pkg::MON_HIGH |=> monitor_pin_out && !monitor_pin_oe_n)
        else $error("monitor not driven high");
    AST_CLEAR_HOLD: assert property (ce && main_reg[synth_pkg::CLR_BIT] |=> counters_held)
        else $error("counters not held by clear bit");
    AST_LOCK_DROP: assert property (ce && !hold_reg && r_pulse && !phase_in_window |=> !digital_lock)
        else $error("lock kept after out-of-window cycle");
    AST_LOCK_COUNT: assert property ($rose(lock_reg) |-> lock_cnt_reg == lock_need)
        else $error("lock declared at wrong cycle count");
    AST_GAIN_FB: assert property (ce && load_fb |=> gain_reg == $past(shift_reg[synth_pkg::GAIN_FB_BIT]))
        else $error("pump gain not taken from feedback word");
    AST_INIT_PUMP: assert property (ce && pwr_reg == synth_pkg::PWR_INIT |=> pump_tristate && !rf_out_en)
        else $error("pump not off during initialisation");
    AST_PD_ASYNC: assert property (ce && pwr_reg == synth_pkg::PWR_RUN && pd_async |=> pwr_reg == synth_pkg::PWR_DOWN ##1 powered_down)
        else $error("async power-down not immediate");
    AST_MUTE: assert property (ce && mute && !lock_reg |=> !rf_out_en)
        else $error("RF output enabled before lock");
    AST_TEST_OFF: assert property (ce && !test_en |=> !ext_band_sel && band_icp_ctrl && sar_icp_ctrl)
        else $error("normal band controls not applied");
    AST_BACKLASH: assert property (ce && abp_code == 2'h2 |=> backlash_width == synth_pkg::ABP_W_LONG)
        else $error("wide backlash width not selected");
endmodule
`default_nettype wire

// ==== verif/host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input  wire logic clk,
    output var logic  ser_clk,
    output var logic  ser_data,
    output var logic  load_strobe
);
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        load_strobe = 1'b0;
    end
    // each level held two cycles so the sampler sees every edge
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            ser_data <= w[i];
            ser_clk <= 1'b0;
            repeat (2) @(posedge clk);
            ser_clk <= 1'b1;
            repeat (2) @(posedge clk);
        end
        ser_clk <= 1'b0;
        ser_data <= ~w[0]; // released data never shows the stale bit
        load_strobe <= 1'b1;
        repeat (2) @(posedge clk);
        load_strobe <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sc, sd, ls, mon, mon_oe_n, tri_st, gain, half, held, pdn, tst, bicp;
    logic lock, rf, psrc, pol, btick, fbp, ext, sar;
    logic ce_i = 1'b1;
    logic rt = 1'b0;
    logic ft = 1'b0;
    logic win = 1'b0;
    logic [1:0] cbias, opwr;
    logic [2:0] icp;
    logic [5:0] bw, modv;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    int n_band = 0;
    int n_fbp = 0;
    int b0 = 0;
    always #20 clk = ~clk;
    host_model i_host_model (.clk(clk), .ser_clk(sc), .ser_data(sd), .load_strobe(ls));
    // ticks, window and enable come from the bench so divider, lock and freeze paths run
    synth_latch_programming i_synth_latch_programming (
        .clk(clk), .rst(rst), .ce(ce_i), .ser_clk(sc), .ser_data(sd), .load_strobe(ls),
        .ref_tick(rt), .fb_tick(ft), .phase_in_window(win),
        .monitor_pin_out(mon), .monitor_pin_oe_n(mon_oe_n), .digital_lock(lock), .rf_out_en(rf),
        .pump_tristate(tri_st), .pump_gain_select(gain), .pump_current(icp), .core_bias(cbias),
        .output_power(opwr), .backlash_width(bw), .prescaler_modulus(modv), .output_halving(half),
        .prescaler_source(psrc), .detector_polarity(pol), .powered_down(pdn), .counters_held(held),
        .band_clk_tick(btick), .fb_pulse(fbp), .test_mode_active(tst), .ext_band_sel(ext),
        .band_icp_ctrl(bicp), .sar_icp_ctrl(sar)
    );
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic conclude;
        if (n_fail == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // one reference tick every second cycle, then time for lock and outputs to settle
    task automatic pulse_ref(input int n, input logic w);
        win <= w;
        repeat (n) begin
            rt <= 1'b1;
            @(posedge clk);
            rt <= 1'b0;
            @(posedge clk);
        end
        repeat (2) @(posedge clk);
    endtask
    // fb_tick held high gives one prescaler tick per cycle
    task automatic pulse_fb(input int n);
        ft <= 1'b1;
        repeat (n) @(posedge clk);
        ft <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // hang guard: fifteen words of about 100 cycles plus about a hundred tick cycles fit well inside
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (btick) n_band <= n_band + 1;
        if (fbp) n_fbp <= n_fbp + 1;
        if (cyc == 5000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("pdn", 1, pdn);
        i_host_model.send(24'h400060);
        chk("tri", 1, tri_st);
        chk("pdn", 1, pdn);
        i_host_model.send(24'h010005);
        chk("bw", synth_pkg::ABP_W_SHORT, bw);
        chk("tst", 0, tst);
        chk("bicp", 1, bicp);
        i_host_model.send(24'h600306);
        chk("pdn", 0, pdn);
        chk("held", 0, held);
        chk("tri", 0, tri_st);
        chk("gain", 1, gain);
        chk("half", 1, half);
        chk("mod", synth_pkg::MOD_16, modv);
        chk("mon", 1, mon);
        chk("oe_n", 0, mon_oe_n);
        // ratio 1, coarse lock: three in-window samples, band clock undivided
        b0 = n_band;
        pulse_ref(2, 1'b1);
        chk("lock", 0, lock);
        pulse_ref(1, 1'b1);
        chk("lock", 1, lock);
        chk("band", 3, n_band - b0);
        pulse_ref(1, 1'b0);
        chk("lock", 0, lock);
        // modulus 16, B 3, A 1: one feedback pulse per 49 ticks
        pulse_fb(48);
        chk("fbp", 0, n_fbp);
        pulse_fb(1);
        chk("fbp", 1, n_fbp);
        // later main writes clear the gain bit: latest writer wins
        for (int k = 0; k < 4; k++) begin
            i_host_model.send({k[1:0], 22'h0000e0});
            chk("mod", k == 0 ? synth_pkg::MOD_8 : k == 1 ? synth_pkg::MOD_16 : synth_pkg::MOD_32, modv);
            chk("gain", 0, gain);
            chk("mon", 0, mon);
        end
        // feedback word sets the gain bit and the prescaler source bit and clears output halving
        i_host_model.send(24'ha00306);
        chk("psrc", 1, psrc);
        chk("half", 0, half);
        chk("gain", 1, gain);
        // test latch is ignored while the test bit is clear
        i_host_model.send(24'h000017);
        chk("ext", 0, ext);
        // test bit, fine lock, ratio 2, band clock halved
        i_host_model.send(24'h1c0009);
        chk("tst", 1, tst);
        chk("ext", 1, ext);
        chk("bicp", 0, bicp);
        chk("sar", 1, sar);
        chk("bw", synth_pkg::ABP_W_NORM, bw);
        // muted until lock, open-drain lock monitor, core bias 2, current settings 5 and 2
        i_host_model.send(24'h0559a8);
        chk("rf", 0, rf);
        chk("cbias", 2, cbias);
        chk("icp", 5, icp);
        chk("gain", 0, gain);
        chk("opwr", 1, opwr);
        chk("pol", 1, pol);
        chk("mod", synth_pkg::MOD_8, modv);
        chk("mon", 0, mon);
        chk("oe_n", 0, mon_oe_n);
        b0 = n_band;
        pulse_ref(8, 1'b1);
        chk("lock", 0, lock);
        chk("rf", 0, rf);
        pulse_ref(2, 1'b1);
        chk("lock", 1, lock);
        chk("rf", 1, rf);
        chk("oe_n", 1, mon_oe_n);
        chk("band", 2, n_band - b0);
        // synchronous power-down lands on the second reference pulse; monitor shows lock
        i_host_model.send(24'h300020);
        chk("mon", 1, mon);
        pulse_ref(2, 1'b1);
        chk("pdn", 0, pdn);
        pulse_ref(2, 1'b1);
        chk("pdn", 1, pdn);
        chk("held", 1, held);
        chk("tri", 1, tri_st);
        chk("rf", 0, rf);
        // clock enable low freezes the port: a word sent meanwhile is never taken
        ce_i <= 1'b0;
        i_host_model.send(24'h000060);
        ce_i <= 1'b1;
        repeat (2) @(posedge clk);
        chk("pdn", 1, pdn);
        chk("mon", 0, mon);
        i_host_model.send(24'h000210);
        chk("held", 1, held);
        chk("tri", 1, tri_st);
        chk("pdn", 0, pdn);
        chk("lock", 0, lock);
        chk("oe_n", 1, mon_oe_n);
        // asynchronous power-down takes effect without any reference pulse
        i_host_model.send(24'h100000);
        chk("pdn", 1, pdn);
        conclude();
    end
endmodule
`default_nettype wire
